// ==== shared/ltdp_pkg.sv ====
// Constants, types and field helpers of the lookup-table data port.
// Assumes a 12-bit APB byte address and 32-bit data words.
`default_nettype none

package ltdp_pkg;

    localparam int LTDP_ADDR_W = 12;
    localparam int LTDP_DATA_W = 32;
    localparam int LTDP_OFFSET_W = 8;
    localparam int LTDP_ENTRIES = 64;
    localparam int LTDP_IDX_W = 6;

    // Byte addresses on the register bus.
    localparam logic [11:0] LTDP_ADDR_TBL_OFFSET = 12'h050;
    localparam logic [11:0] LTDP_ADDR_TBL_DATA = 12'h054;
    localparam logic [11:0] LTDP_ADDR_WIN_SIZE = 12'h068;
    localparam logic [11:0] LTDP_ADDR_MIRROR_FIRST = 12'h100;
    localparam logic [11:0] LTDP_ADDR_MIRROR_LAST = 12'h1FF;

    // Entry field positions.
    localparam int LTDP_VALID_BIT = 0;
    localparam int LTDP_PREFETCH_BIT = 3;
    localparam int LTDP_BASE_LO_LSB = 8;
    localparam int LTDP_BASE_LO_MSB = 24;
    localparam int LTDP_BASE_HI_LSB = 25;
    localparam int LTDP_BASE_HI_MSB = 31;
    localparam int LTDP_WIN_SIZE_BIT = 0;

    // Bits that hold state in an entry; everything else reads as zero.
    localparam logic [31:0] LTDP_MASK_ALWAYS = 32'hFE000009;
    localparam logic [31:0] LTDP_MASK_BASE_LO = 32'h01FFFF00;

    // Values after reset.
    localparam logic [31:0] LTDP_RST_ENTRY = 32'h00000000;
    localparam logic [7:0] LTDP_RST_OFFSET = 8'h00;
    localparam logic LTDP_RST_WIN_SIZE = 1'b0;

    // Window granularity encodings.
    localparam logic LTDP_WIN_256B = 1'b0;
    localparam logic LTDP_WIN_32MB = 1'b1;

    typedef struct packed {
        logic [LTDP_ENTRIES-1:0][LTDP_DATA_W-1:0] entry;
    } ltdp_mem_s;

    typedef struct packed {
        logic [LTDP_OFFSET_W-1:0] offset;
        logic win_size;
        logic [LTDP_DATA_W-1:0] rdata;
        logic err;
        logic [LTDP_IDX_W-1:0] last_idx;
    } ltdp_regs_s;

    // Writable and readable bits of an entry for the given window size.
    function automatic logic [31:0] ltdp_entry_mask(input logic win_size);
        ltdp_entry_mask = (win_size == LTDP_WIN_32MB) ? LTDP_MASK_ALWAYS :
                          (LTDP_MASK_ALWAYS | LTDP_MASK_BASE_LO);
    endfunction

    // Expands APB byte strobes into a bit mask.
    function automatic logic [31:0] ltdp_strb_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h00000000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        ltdp_strb_mask = m;
    endfunction

endpackage

`default_nettype wire

// ==== rtl/ltdp_entry_mem.sv ====
// Flip-flop storage of the translation entries, one write port and two
// index-addressed read ports.
// Assumes the caller masks write data to the bits that may hold state.
`timescale 1ns/10ps
`default_nettype none

module ltdp_entry_mem
    import ltdp_pkg::*;
(
    input wire logic pclk, // Bus clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic wr_en, // Store wr_data this edge.
    input wire logic [LTDP_IDX_W-1:0] wr_idx, // Entry to store.
    input wire logic [31:0] wr_data, // Value to store.
    input wire logic [LTDP_IDX_W-1:0] rd_idx, // Entry for the bus.
    output logic [31:0] rd_data, // Contents at rd_idx.
    input wire logic [LTDP_IDX_W-1:0] chk_idx, // Entry for checking.
    output logic [31:0] chk_data // Contents at chk_idx.
);

    ltdp_mem_s mem_q;
    ltdp_mem_s mem_d;

    always_comb begin
        mem_d = mem_q;
        if (wr_en) begin
            mem_d.entry[wr_idx] = wr_data;
        end
    end

    // Every entry clears, so valid and prefetchable flags start at zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_q <= {LTDP_ENTRIES{LTDP_RST_ENTRY}};
        end else begin
            mem_q <= mem_d;
        end
    end

    assign rd_data = mem_q.entry[rd_idx];
    assign chk_data = mem_q.entry[chk_idx];

endmodule // ltdp_entry_mem

`default_nettype wire

// ==== rtl/ltdp_top.sv ====
// APB register bank giving software access to the address-translation
// lookup table through an offset register and a data window.
// Assumes an APB master on pclk; no wait states beyond the access phase.
`timescale 1ns/10ps
`default_nettype none

module ltdp_top
    import ltdp_pkg::*;
(
    input wire logic pclk, // Bus clock, 10 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    input wire logic [3:0] pstrb, // APB byte strobes.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    output logic [7:0] lut_offset, // Selected entry byte offset.
    output logic win_size_32mb // Window granularity, high for 32MB.
);

    ltdp_regs_s regs_q;
    ltdp_regs_s regs_d;

    logic setup;
    logic access;
    logic hit_offset;
    logic hit_data;
    logic hit_size;
    logic hit_mirror;
    logic unmapped;
    logic [LTDP_IDX_W-1:0] sel_idx;
    logic [31:0] entry_rd;
    logic [31:0] entry_chk;
    logic [31:0] entry_mask;
    logic [31:0] byte_mask;
    logic mem_wr;
    logic [31:0] mem_wdata;

    // Word compare only; the two low address bits are not decoded.
    function automatic logic word_hit(input logic [11:0] a,
                                      input logic [11:0] b);
        word_hit = (a[11:2] == b[11:2]);
    endfunction

    assign setup = psel && !penable;
    assign access = psel && penable;

    assign hit_offset = word_hit(paddr, LTDP_ADDR_TBL_OFFSET);
    assign hit_data = word_hit(paddr, LTDP_ADDR_TBL_DATA);
    assign hit_size = word_hit(paddr, LTDP_ADDR_WIN_SIZE);
    // The mirror spans the whole block; the index drops the two low address
    // bits, so any byte address inside an entry's word reaches that entry.
    assign hit_mirror = (paddr >= LTDP_ADDR_MIRROR_FIRST) &&
                        (paddr <= LTDP_ADDR_MIRROR_LAST);
    assign unmapped = !(hit_offset || hit_data || hit_size || hit_mirror);

    // The data window trusts the offset already loaded by software; the
    // mirror addresses the entry directly from the bus address.
    assign sel_idx = hit_mirror ? paddr[7:2] :
                     regs_q.offset[7:2];

    assign entry_mask = ltdp_entry_mask(regs_q.win_size);
    assign byte_mask = ltdp_strb_mask(pstrb);

    ltdp_entry_mem u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(mem_wr),
        .wr_idx(sel_idx),
        .wr_data(mem_wdata),
        .rd_idx(sel_idx),
        .rd_data(entry_rd),
        .chk_idx(regs_q.last_idx),
        .chk_data(entry_chk)
    );

    // Read-modify-write keeps lanes without a strobe; the mask drops the
    // reserved bits and, in 32MB mode, the low base bits.
    // A write in 32MB mode therefore clears the stored low base bits, so
    // software that switches back to 256B mode finds zeros there.
    assign mem_wr = access && pwrite && !regs_q.err &&
                    (hit_data || hit_mirror);
    assign mem_wdata = ((entry_rd & ~byte_mask) | (pwdata & byte_mask)) &
                       entry_mask;

    always_comb begin
        regs_d = regs_q;
        if (setup) begin
            // The refusal is decided once, in setup, and holds through the
            // access phase, which is what blocks the write there.
            regs_d.err = unmapped;
            regs_d.rdata = 32'h00000000;
            if (!pwrite) begin
                if (hit_offset) begin
                    regs_d.rdata = {24'h000000, regs_q.offset};
                end else if (hit_size) begin
                    regs_d.rdata = {31'h0, regs_q.win_size};
                end else if (hit_data || hit_mirror) begin
                    regs_d.rdata = entry_rd & entry_mask;
                end
            end
        end
        if (access) begin
            regs_d.last_idx = sel_idx;
            if (pwrite && !regs_q.err && pstrb[0]) begin
                if (hit_offset) begin
                    regs_d.offset = pwdata[7:0];
                end
                if (hit_size) begin
                    regs_d.win_size = pwdata[LTDP_WIN_SIZE_BIT];
                end
            end
        end
    end

    // Read data clears at reset so a read before any setup returns zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regs_q.offset <= LTDP_RST_OFFSET;
            regs_q.win_size <= LTDP_RST_WIN_SIZE;
            regs_q.rdata <= 32'h00000000;
            regs_q.err <= 1'b0;
            regs_q.last_idx <= 6'h00;
        end else begin
            regs_q <= regs_d;
        end
    end

    // Read data is captured in the setup cycle, so the access phase can
    // complete at once without a combinational path from the table.
    assign pready = access;
    assign pslverr = access && regs_q.err;
    assign prdata = regs_q.rdata;
    assign lut_offset = regs_q.offset;
    assign win_size_32mb = regs_q.win_size;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_data_read_entry:
    assert property (setup && !pwrite && hit_data |=>
                     prdata == ($past(entry_rd) &
                                ltdp_entry_mask($past(regs_q.win_size))))
    else $error("data read does not return the selected entry");

    a_data_write_store:
    assert property (access && pwrite && hit_data && !pslverr &&
                     pstrb == 4'hF |=>
                     entry_chk == ($past(pwdata) &
                                   ltdp_entry_mask($past(regs_q.win_size))))
    else $error("data write was not stored in the selected entry");

    a_valid_flag:
    assert property (mem_wr && pstrb[0] |=>
                     entry_chk[LTDP_VALID_BIT] == $past(pwdata[0]))
    else $error("valid flag does not follow the written value");

    a_prefetch_flag:
    assert property (mem_wr && pstrb[0] |=>
                     entry_chk[LTDP_PREFETCH_BIT] == $past(pwdata[3]))
    else $error("prefetchable flag does not follow the written value");

    a_base_256b_rw:
    assert property (mem_wr && pstrb == 4'hF &&
                     regs_q.win_size == LTDP_WIN_256B |=>
                     entry_chk[24:8] == $past(pwdata[24:8]))
    else $error("low base bits not writable in 256B mode");

    a_base_32mb_ro:
    assert property (pready && !pwrite && (hit_data || hit_mirror) &&
                     regs_q.win_size == LTDP_WIN_32MB |->
                     prdata[24:8] == 17'h0)
    else $error("low base bits not reserved in 32MB mode");

    a_upper_base_rw:
    assert property (mem_wr && pstrb[3] |=>
                     entry_chk[31:25] == $past(pwdata[31:25]))
    else $error("upper base bits not writable");

    a_mirror_read:
    assert property (setup && !pwrite && hit_mirror |-> sel_idx == paddr[7:2]
                     ##1 prdata == ($past(entry_rd) & entry_mask))
    else $error("mirror read does not return the addressed entry");

    a_offset_select:
    assert property (psel && hit_data |-> sel_idx == regs_q.offset[7:2])
    else $error("data window ignores the offset register");

    a_unmapped_error:
    assert property (setup && unmapped ##1 access |->
                     (pslverr && !mem_wr) ##1
                     ($stable(regs_q.offset) && $stable(regs_q.win_size)))
    else $error("unmapped access not refused");

    a_reserved_zero:
    assert property (pready && !pwrite && (hit_data || hit_mirror) |->
                     prdata[7:4] == 4'h0 && prdata[2:1] == 2'h0)
    else $error("reserved entry bits read nonzero");

    // Register side effects: offset and size move only on an accepted
    // write, so a stray access cannot retarget the table.
    a_offset_write:
    assert property (access && pwrite && hit_offset && !pslverr &&
                     pstrb[0] |=> lut_offset == $past(pwdata[7:0]))
    else $error("offset register did not take the written byte");

    a_offset_hold:
    assert property (!(access && pwrite && hit_offset) |=>
                     $stable(lut_offset))
    else $error("offset register changed without a write");

    a_offset_readback:
    assert property (setup && !pwrite && hit_offset |=>
                     prdata == {24'h000000, $past(regs_q.offset)})
    else $error("offset register reads back wrong");

    a_size_write:
    assert property (access && pwrite && hit_size && !pslverr &&
                     pstrb[0] |=> win_size_32mb == $past(pwdata[0]))
    else $error("window size did not take the written bit");

    a_size_hold:
    assert property (!(access && pwrite && hit_size) |=>
                     $stable(win_size_32mb))
    else $error("window size changed without a write");

    a_size_readback:
    assert property (setup && !pwrite && hit_size |=>
                     prdata == {31'h0, $past(regs_q.win_size)})
    else $error("window size reads back wrong");

    // Table side effects: only a write may touch an entry, only the lanes
    // it strobes plus, in 32MB mode, all low base bits, and never the bits that the layout reserves.
    a_read_no_store:
    assert property (access && !pwrite |-> !mem_wr)
    else $error("read access wrote the table");

    a_data_index:
    assert property (mem_wr && hit_data |=>
                     regs_q.last_idx == $past(regs_q.offset[7:2]))
    else $error("data write went to an entry the offset does not select");

    a_mirror_store:
    assert property (mem_wr && hit_mirror && pstrb == 4'hF |=>
                     entry_chk == ($past(pwdata) & $past(entry_mask)))
    else $error("mirror write was not stored in the addressed entry");

    a_strobe_keep:
    assert property (mem_wr && !pstrb[1] |=>
                     entry_chk[15:8] == ($past(entry_rd[15:8]) &
                                         $past(entry_mask[15:8])))
    else $error("write changed a byte lane without a strobe");

    a_no_reserved_bits:
    assert property (mem_wr |=>
                     (entry_chk & ~(LTDP_MASK_ALWAYS | LTDP_MASK_BASE_LO)) ==
                     32'h00000000)
    else $error("a reserved entry bit was stored");

    a_32mb_clears_low:
    assert property (mem_wr && regs_q.win_size == LTDP_WIN_32MB |=>
                     entry_chk[24:8] == 17'h0)
    else $error("low base bits stored in 32MB mode");

    // Bus side: read data stands from one setup edge to the next, there
    // are no wait states, and a refused access returns nothing.
    a_prdata_stable:
    assert property (!setup |=> $stable(prdata))
    else $error("read data changed outside a setup cycle");

    a_ready_no_wait:
    assert property (access |-> pready)
    else $error("access phase was stalled");

    a_unmapped_read_zero:
    assert property (setup && unmapped && !pwrite |=>
                     prdata == 32'h00000000)
    else $error("unmapped read returned data");

    a_error_in_access:
    assert property (pslverr |-> access)
    else $error("error response outside the access phase");

endmodule // ltdp_top

`default_nettype wire

// ==== testbench/ltdp_tb_top.sv ====
// Self-checking bench for the lookup-table data port register bank.
// Assumes ltdp_top on a 10 MHz pclk and an APB master modelled here.
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e); end end

module ltdp_tb_top;
    import ltdp_pkg::*;

    typedef struct packed {
        logic w;
        logic [11:0] a;
        logic [31:0] d;
        logic [3:0] s;
        logic [31:0] e;
        logic er;
    } ltdp_row_s;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] lut_offset;
    logic win_size_32mb;
    logic [31:0] rd;
    logic er;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    ltdp_row_s rows [0:23];

    ltdp_top uut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .lut_offset(lut_offset),
        .win_size_32mb(win_size_32mb)
    );

    always #50 pclk = ~pclk;

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // The request stays put until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 100) begin
            n++;
            @(posedge pclk);
        end
        `CHK(n, 0)
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            results();
        end
    end

    initial begin
        rows = '{
            '{1'b1, 12'h050, 32'hFFFFFF08, 4'hF, 32'h0, 1'b0},
            '{1'b1, 12'h054, 32'hFFFFFFFF, 4'hF, 32'h0, 1'b0},
            '{1'b0, 12'h054, 32'h0, 4'h0, 32'hFFFFFF09, 1'b0},
            '{1'b0, 12'h108, 32'h0, 4'h0, 32'hFFFFFF09, 1'b0},
            '{1'b0, 12'h050, 32'h0, 4'h0, 32'h00000008, 1'b0},
            '{1'b1, 12'h104, 32'h12345601, 4'hF, 32'h0, 1'b0},
            '{1'b1, 12'h050, 32'h00000004, 4'hF, 32'h0, 1'b0},
            '{1'b0, 12'h054, 32'h0, 4'h0, 32'h12345601, 1'b0},
            '{1'b1, 12'h100, 32'hFFFFFFFF, 4'hF, 32'h0, 1'b0},
            '{1'b0, 12'h100, 32'h0, 4'h0, 32'hFFFFFF09, 1'b0},
            '{1'b1, 12'h068, 32'h00000001, 4'hF, 32'h0, 1'b0},
            '{1'b0, 12'h068, 32'h0, 4'h0, 32'h00000001, 1'b0},
            '{1'b1, 12'h054, 32'hFFFFFFFF, 4'hF, 32'h0, 1'b0},
            '{1'b0, 12'h054, 32'h0, 4'h0, 32'hFE000009, 1'b0},
            '{1'b1, 12'h068, 32'h00000000, 4'hF, 32'h0, 1'b0},
            '{1'b0, 12'h104, 32'h0, 4'h0, 32'hFE000009, 1'b0},
            '{1'b0, 12'h10C, 32'h0, 4'h0, 32'h00000000, 1'b0},
            '{1'b1, 12'h050, 32'h00000008, 4'hF, 32'h0, 1'b0},
            '{1'b1, 12'h054, 32'h00000000, 4'h1, 32'h0, 1'b0},
            '{1'b0, 12'h054, 32'h0, 4'h0, 32'hFFFFFF00, 1'b0},
            '{1'b1, 12'h058, 32'hFFFFFFFF, 4'hF, 32'h0, 1'b1},
            '{1'b0, 12'h058, 32'h0, 4'h0, 32'h00000000, 1'b1},
            '{1'b0, 12'h04C, 32'h0, 4'h0, 32'h00000000, 1'b1},
            '{1'b0, 12'h050, 32'h0, 4'h0, 32'h00000008, 1'b0}
        };
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            apb(rows[i].w, rows[i].a, rows[i].d, rows[i].s, rd, er);
            `CHK(er, rows[i].er)
            if (rows[i].w == 1'b0) begin
                `CHK(rd, rows[i].e)
            end
        end
        `CHK(lut_offset, 8'h08)
        apb(1'b1, 12'h068, 32'h00000001, 4'hF, rd, er);
        // The size bit moves at the edge that ends the access, so look later.
        @(posedge pclk);
        `CHK(win_size_32mb, 1'b1)
        // Entry 0 still holds low base bits from 256B mode; they read as zero.
        apb(1'b0, 12'h100, 32'h0, 4'h0, rd, er);
        `CHK(rd, 32'hFE000009)
        // A second reset in mid-run must clear entries written earlier.
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        `CHK(lut_offset, 8'h00)
        `CHK(win_size_32mb, 1'b0)
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'h100 + 12'(4 * i), 32'h0, 4'h0, rd, er);
            `CHK(rd, 32'h00000000)
        end
        apb(1'b0, 12'h054, 32'h0, 4'h0, rd, er);
        `CHK(rd, 32'h00000000)
        results();
    end

endmodule // ltdp_tb_top

`undef CHK
`default_nettype wire
